// ===== src/fzv_vote.sv
// Flame zone voting top: zone qualification, voting, latching and chain bus.
// Operation
// - Consecutive gates are sum of weighted switches.
// - Gate requirement below two becomes two.
// - Non-latching fires only on simultaneous zones.
// - Latching fires on cumulative zone reports.
// - Arrangement closed selects two separate groups.
// - Group B needs one or two zones.
// - Group A needs one or two zones.
// - Common voting threshold is one to seven.
// - Chained controllers share zone counts over bus.
// - Common mode turns output A into strobe.
// - Test mode always votes as latching.
// - Test mode keeps outputs quiet, indicators live.
// - Latching output holds until controller reset.
// - Open role switch makes controller master.
// - Last slave makes final group B decision.
// - Fault and alarm never travel the bus.
// - Count detector pulses within each gate.
// - Zone fires after enough consecutive qualified gates.
`timescale 1ns/10ps
`include "fzv_cfg.svh"
module fzv_vote
    import fzv_pkg::*;
(
    input wire logic sys_clk, // System clock, 100 MHz.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [7:0] det_pulse, // Detector pulse pins.
    input wire logic gate_tick, // Gate interval boundary.
    input wire logic [3:0] sw_cnt, // Counts per gate switches.
    input wire logic [3:0] sw_gates, // Consecutive gate switches.
    input wire logic [3:0] sw_vote, // Fire logic selection switches.
    input wire logic sw_nonlatch, // Closed means non-latching.
    input wire logic sw_slave, // Closed means slave.
    input wire logic test_pin, // Test mode pin.
    input wire logic creset_pin, // Controller reset pin.
    input wire logic [6:0] bus_cnt_in, // Upstream zone count.
    input wire logic bus_strb_in, // Upstream data strobe.
    output logic [6:0] bus_cnt_out, // Downstream zone count.
    output logic fire_a_o, // Fire logic A or data strobe.
    output logic fire_b_o, // Fire logic B output.
    output logic led_fire_a, // Fire logic A indicator.
    output logic led_fire_b, // Fire logic B indicator.
    output logic [7:0] led_zone // Zone indicators.
);
    fzv_cfg_t cfg_q;
    fzv_strb_t st_q;
    logic cfg_ok_q;
    logic [7:0] pins_s;
    logic [7:0] pins_d_q;
    logic [7:0] pulse;
    logic [7:0] zfire;
    logic [7:0] seen_q;
    logic [7:0] vz;
    logic [2:0] ctl_s;
    logic [6:0] up_q;
    logic strb_d_q;
    logic test_m;
    logic clr;
    logic latch_eff;
    logic [6:0] total;
    logic [2:0] thr_a;
    logic [2:0] thr_b;
    logic [2:0] thr_c;
    logic vote_a;
    logic vote_b;
    logic led_a_q;
    logic led_b_q;
    logic [6:0] out_q;

    // ----------------------------------------
    // Helper functions
    // ----------------------------------------
    function automatic logic [2:0] pop4(input logic [3:0] v);
        pop4 = {2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]};
    endfunction

    function automatic logic [3:0] floor2(input logic [3:0] v, input logic [3:0] m);
        floor2 = (v < m) ? m : v;
    endfunction

    function automatic logic [2:0] need_of(input logic two);
        need_of = two ? `FZV_TWO_OF : `FZV_ONE_OF;
    endfunction

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    fzv_sync #(.W(8)) u_det_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d(det_pulse),
        .q(pins_s)
    );

    fzv_sync #(.W(3)) u_ctl_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .d({test_pin, creset_pin, bus_strb_in}),
        .q(ctl_s)
    );

    assign test_m = ctl_s[2];
    assign clr = ctl_s[1];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pins_d_q <= '0;
            strb_d_q <= 1'b0;
        end else begin
            pins_d_q <= pins_s;
            strb_d_q <= ctl_s[0];
        end
    end

    assign pulse = pins_s & ~pins_d_q;

    // ----------------------------------------
    // Switch capture
    // ----------------------------------------
    // Switches are taken once, on the first edge after reset release.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ok_q <= 1'b0;
            cfg_q <= '0;
        end else if (!cfg_ok_q) begin
            cfg_ok_q <= 1'b1;
            cfg_q.cnt <= floor2(sw_cnt, `FZV_MIN_CNT);
            cfg_q.gates <= floor2(sw_gates, `FZV_MIN_GATES);
            cfg_q.sep <= sw_vote[`FZV_SW_SEP];
            cfg_q.vthr <= {sw_vote[`FZV_SW_W4], sw_vote[`FZV_SW_W2], sw_vote[`FZV_SW_W1]};
            cfg_q.thr_b2 <= sw_vote[`FZV_SW_W2];
            cfg_q.thr_a2 <= sw_vote[`FZV_SW_W4];
            cfg_q.nonlatch <= sw_nonlatch;
            cfg_q.slave <= sw_slave;
        end
    end

    // ----------------------------------------
    // Zone qualification
    // ----------------------------------------
    for (genvar z = 0; z < 8; z++) begin : g_zone
        fzv_zone u_zone (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pulse(pulse[z]),
            .gate_tick(gate_tick && cfg_ok_q),
            .cnt_req(cfg_q.cnt),
            .gates_req(cfg_q.gates),
            .fire(zfire[z])
        );
    end

    // Zones seen in fire stay remembered until a controller reset.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= '0;
        end else if (clr) begin
            seen_q <= '0;
        end else begin
            seen_q <= seen_q | zfire;
        end
    end

    assign latch_eff = test_m || !cfg_q.nonlatch;
    assign vz = latch_eff ? seen_q : zfire;
    assign led_zone = seen_q;

    // ----------------------------------------
    // Chain bus
    // ----------------------------------------
    // The upstream word is stable when its strobe arrives; a master ignores it.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= '0;
        end else if (!cfg_q.slave || cfg_q.sep) begin
            up_q <= '0;
        end else if (ctl_s[0] && !strb_d_q) begin
            up_q <= bus_cnt_in;
        end
    end

    assign total = up_q + {3'h0, {1'b0, pop4(vz[3:0])} + {1'b0, pop4(vz[7:4])}};

    // Only the zone count goes downstream; fault and alarm stay local.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= '0;
        end else if (test_m || cfg_q.sep) begin
            out_q <= '0;
        end else begin
            out_q <= total;
        end
    end

    assign bus_cnt_out = out_q;

    // A strobe follows each change of the downstream word, except a change that comes one cycle after the last one.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= FZV_S_IDLE;
        end else begin
            case (st_q)
                FZV_S_IDLE: begin
                    if (out_q != total && !test_m && !cfg_q.sep) begin
                        st_q <= FZV_S_PULSE;
                    end
                end
                FZV_S_PULSE: begin
                    st_q <= FZV_S_IDLE;
                end
                default: begin
                    st_q <= FZV_S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Voting
    // ----------------------------------------
    assign thr_a = need_of(cfg_q.thr_a2);
    assign thr_b = need_of(cfg_q.thr_b2);
    assign thr_c = (cfg_q.vthr == 3'h0) ? `FZV_MIN_VOTE : cfg_q.vthr;

    always_comb begin
        vote_a = 1'b0;
        vote_b = 1'b0;
        if (cfg_ok_q) begin
            if (cfg_q.sep) begin
                vote_a = pop4(vz[3:0]) >= thr_a;
                vote_b = pop4(vz[7:4]) >= thr_b;
            end else begin
                vote_b = total >= {4'h0, thr_c};
            end
        end
    end

    // Latched results hold until a controller reset.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            led_a_q <= 1'b0;
            led_b_q <= 1'b0;
        end else if (clr) begin
            led_a_q <= 1'b0;
            led_b_q <= 1'b0;
        end else begin
            led_a_q <= vote_a || (latch_eff && led_a_q);
            led_b_q <= vote_b || (latch_eff && led_b_q);
        end
    end

    assign led_fire_a = led_a_q;
    assign led_fire_b = led_b_q;

    // ----------------------------------------
    // External outputs
    // ----------------------------------------
    always_comb begin
        fire_a_o = 1'b0;
        fire_b_o = 1'b0;
        if (!test_m) begin
            fire_b_o = led_b_q;
            fire_a_o = cfg_q.sep ? led_a_q : (st_q == FZV_S_PULSE);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    gates_floor_a: assert property (cfg_ok_q |-> cfg_q.gates >= `FZV_MIN_GATES)
        else $error("Consecutive gate requirement below two.");
    test_quiet_a: assert property (test_m |-> !fire_a_o && !fire_b_o && bus_cnt_out == 7'h00)
        else $error("External output active in test mode.");
    latch_hold_a: assert property (latch_eff && led_b_q && !clr |=> led_b_q)
        else $error("Latched fire logic B dropped without reset.");
    nonlatch_b_a: assert property (!latch_eff && !clr ##1 !latch_eff |-> led_b_q == $past(vote_b))
        else $error("Non-latching B does not follow the vote.");
    sep_a_vote_a: assert property (cfg_q.sep && vote_a && !clr |=> led_a_q)
        else $error("Group A vote did not raise its indicator.");
    test_latch_a: assert property (test_m |-> vz == seen_q)
        else $error("Test mode not voting as latching.");
    strobe_one_a: assert property (fire_a_o && !cfg_q.sep |=> !fire_a_o)
        else $error("Data strobe longer than one cycle.");
    master_up_a: assert property (cfg_ok_q && !cfg_q.slave |=> up_q == 7'h00)
        else $error("Master took an upstream count.");
    common_a_a: assert property (cfg_ok_q && !cfg_q.sep |-> !vote_a)
        else $error("Group A voted in common mode.");
    slave_take_a: assert property (cfg_q.slave && !cfg_q.sep && ctl_s[0] && !strb_d_q
        |=> up_q == $past(bus_cnt_in))
        else $error("Slave missed the upstream word.");
    up_hold_a: assert property (cfg_q.slave && !cfg_q.sep && !(ctl_s[0] && !strb_d_q)
        |=> $stable(up_q))
        else $error("Upstream word changed without a strobe.");
    out_follow_a: assert property (cfg_ok_q && !test_m && !cfg_q.sep
        |=> bus_cnt_out == $past(total))
        else $error("Downstream word does not carry the zone count.");
    strobe_word_a: assert property (!cfg_q.sep && fire_a_o
        |-> bus_cnt_out != $past(bus_cnt_out))
        else $error("Data strobe without a new downstream word.");
    sep_bus_zero_a: assert property (cfg_ok_q && cfg_q.sep |=> bus_cnt_out == 7'h00)
        else $error("Downstream word active in separate voting.");
    sep_idle_a: assert property (cfg_ok_q && cfg_q.sep |-> st_q == FZV_S_IDLE)
        else $error("Data strobe armed in separate voting.");
    vote_gate_a: assert property (!cfg_ok_q |-> !vote_a && !vote_b)
        else $error("Vote before the switches were taken.");
    cfg_once_a: assert property (cfg_ok_q |=> cfg_ok_q)
        else $error("Switch capture flag dropped.");
    cfg_stable_a: assert property (cfg_ok_q |=> $stable(cfg_q))
        else $error("Switch settings changed after capture.");
    cnt_floor_a: assert property (cfg_ok_q |-> cfg_q.cnt >= `FZV_MIN_CNT)
        else $error("Counts per gate requirement below two.");
    latch_a_hold_a: assert property (latch_eff && led_a_q && !clr |=> led_a_q)
        else $error("Latched fire logic A dropped without reset.");
    nonlatch_a_a: assert property (!latch_eff && !clr ##1 !latch_eff
        |-> led_a_q == $past(vote_a))
        else $error("Non-latching A does not follow the vote.");
    live_vote_a: assert property (!latch_eff |-> vz == zfire)
        else $error("Non-latching vote does not use live zones.");
    sep_b_vote_a: assert property (cfg_q.sep && vote_b && !clr |=> led_b_q)
        else $error("Group B vote did not raise its indicator.");
    common_vote_a: assert property (!cfg_q.sep && vote_b && !clr |=> led_b_q)
        else $error("Common vote did not raise fire logic B.");
    a_thr_two_a: assert property (cfg_q.sep && cfg_q.thr_a2 && pop4(vz[3:0]) < 3'h2
        |-> !vote_a)
        else $error("Group A voted with fewer than two zones.");
    b_thr_two_a: assert property (cfg_q.sep && cfg_q.thr_b2 && pop4(vz[7:4]) < 3'h2
        |-> !vote_b)
        else $error("Group B voted with fewer than two zones.");
    clr_leds_a: assert property (clr |=> !led_a_q && !led_b_q)
        else $error("Controller reset left a fire indicator on.");
    clr_zones_a: assert property (clr |=> seen_q == 8'h00)
        else $error("Controller reset left a zone remembered.");
    seen_merge_a: assert property (!clr |=> seen_q == ($past(seen_q) | $past(zfire)))
        else $error("Remembered zones lost or gained without fire.");

    // ----------------------------------------
    // Coverage
    // ----------------------------------------
    sep_fire_c: cover property (cfg_q.sep && fire_a_o ##1 fire_b_o);
    common_fire_c: cover property (!cfg_q.sep && cfg_q.slave && fire_b_o);
    test_led_c: cover property (test_m && led_fire_b);
    strobe_out_c: cover property (!cfg_q.sep && fire_a_o);
    creset_clear_c: cover property (clr && led_fire_a);
endmodule

// ===== src/fzv_cfg.svh
// Constants for the flame zone voting block.
`ifndef FZV_CFG_SVH
`define FZV_CFG_SVH
`define FZV_MIN_GATES 4'h2
`define FZV_MIN_CNT 4'h2
`define FZV_MIN_VOTE 3'h1
`define FZV_ONE_OF 3'h1
`define FZV_TWO_OF 3'h2
`define FZV_SW_SEP 0
`define FZV_SW_W1 1
`define FZV_SW_W2 2
`define FZV_SW_W4 3
`define FZV_SYNC_W 8'h0B
`endif

// ===== src/fzv_pkg.sv
// Types shared by the flame zone voting block.
package fzv_pkg;
    typedef struct packed {
        logic [3:0] cnt;
        logic [3:0] gates;
        logic sep;
        logic [2:0] vthr;
        logic thr_b2;
        logic thr_a2;
        logic nonlatch;
        logic slave;
    } fzv_cfg_t;
    typedef enum logic [1:0] {
        FZV_S_IDLE = 2'b01,
        FZV_S_PULSE = 2'b10
    } fzv_strb_t;
endpackage

// ===== src/fzv_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps
module fzv_sync #(
    parameter int W = 1
) (
    sys_clk, // System clock.
    rst_n, // Asynchronous reset, active low.
    d, // Asynchronous input.
    q // Filtered, synchronised output.
);
    input wire logic sys_clk;
    input wire logic rst_n;
    input wire logic [W-1:0] d;
    output logic [W-1:0] q;
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ===== src/fzv_zone.sv
// One detector zone: pulse counting per gate and consecutive gate qualification.
`timescale 1ns/10ps
module fzv_zone
    import fzv_pkg::*;
(
    input wire logic sys_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic pulse, // One-cycle detector pulse.
    input wire logic gate_tick, // End of a gate interval.
    input wire logic [3:0] cnt_req, // Counts needed per gate.
    input wire logic [3:0] gates_req, // Consecutive gates needed.
    output logic fire // Zone fire condition.
);
    logic [3:0] pcnt_q;
    logic [3:0] run_q;
    logic qual;

    assign qual = (pcnt_q >= cnt_req);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_q <= '0;
        end else if (gate_tick) begin
            pcnt_q <= {3'h0, pulse};
        end else if (pulse && pcnt_q != 4'hF) begin
            pcnt_q <= pcnt_q + 4'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= '0;
            fire <= 1'b0;
        end else if (gate_tick) begin
            if (!qual) begin
                run_q <= '0;
                fire <= 1'b0;
            end else begin
                if (run_q != 4'hF) begin
                    run_q <= run_q + 4'h1;
                end
                fire <= ({1'b0, run_q} + 5'h01 >= {1'b0, gates_req});
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    fail_clears_run_a: assert property (gate_tick && !qual |=> run_q == 4'h0 && !fire)
        else $error("Failed gate did not clear the zone run.");
endmodule

// ===== tb/fzv_field.sv
// Far-side model: flame detectors on the zone pins and an upstream peer controller.
`timescale 1ns/10ps
module fzv_field #(
    parameter int HOLD = 4
) (
    input wire logic sys_clk, // System clock.
    input wire logic go, // Starts a pulse burst.
    input wire logic [7:0] zmask, // Zones that pulse in the burst.
    input wire logic [3:0] npulse, // Pulses per zone in the burst.
    input wire logic up_go, // Sends a new upstream word.
    input wire logic [6:0] up_cnt, // Upstream zone count to send.
    output logic [7:0] det_pulse, // Detector pulse pins.
    output logic busy, // Burst in progress.
    output logic [6:0] bus_cnt_in, // Upstream word toward the block.
    output logic bus_strb_in // Upstream strobe toward the block.
);
    logic [4:0] ph_q = 5'h00;
    logic [3:0] tm_q = 4'h0;
    logic [3:0] sc_q = 4'h0;
    logic [6:0] w_q = 7'h00;

    // Odd phases drive the pins high, so each pulse is HOLD cycles low then HOLD high.
    assign busy = (ph_q != 5'h00);
    assign det_pulse = ph_q[0] ? zmask : 8'h00;
    assign bus_cnt_in = w_q;
    assign bus_strb_in = (sc_q != 4'h0) && (sc_q <= 4'h6);

    always_ff @(posedge sys_clk) begin
        if (go) begin
            ph_q <= {npulse, 1'b0};
            tm_q <= 4'(HOLD - 1);
        end else if (ph_q != 5'h00) begin
            if (tm_q == 4'h0) begin
                ph_q <= ph_q - 5'h01;
                tm_q <= 4'(HOLD - 1);
            end else begin
                tm_q <= tm_q - 4'h1;
            end
        end
    end

    // The word settles two cycles before the strobe rises and stays until the next send.
    always_ff @(posedge sys_clk) begin
        if (up_go) begin
            w_q <= up_cnt;
            sc_q <= 4'h8;
        end else if (sc_q != 4'h0) begin
            sc_q <= sc_q - 4'h1;
        end
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the flame zone voting block.
`timescale 1ns/10ps
module testbench;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic gate_tick = 1'b0;
    logic [3:0] sw_cnt = 4'h1;
    logic [3:0] sw_gates = 4'h1;
    logic [3:0] sw_vote = 4'h1;
    logic sw_nonlatch = 1'b0;
    logic sw_slave = 1'b0;
    logic test_pin = 1'b0;
    logic creset_pin = 1'b0;
    logic go = 1'b0;
    logic up_go = 1'b0;
    logic [7:0] zmask = 8'h00;
    logic [3:0] npulse = 4'h0;
    logic [6:0] up_cnt = 7'h00;
    logic [7:0] det_pulse;
    logic fbusy;
    logic [6:0] bus_cnt_in;
    logic bus_strb_in;
    logic [6:0] bus_cnt_out;
    logic fire_a_o;
    logic fire_b_o;
    logic led_fire_a;
    logic led_fire_b;
    logic [7:0] led_zone;
    int err_total = 0;
    int cmp_count = 0;
    int strobes = 0;

    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) if (fire_a_o === 1'b1) strobes++;

    fzv_vote i_fzv_vote (
        .sys_clk(sys_clk), .rst_n(rst_n), .det_pulse(det_pulse), .gate_tick(gate_tick),
        .sw_cnt(sw_cnt), .sw_gates(sw_gates), .sw_vote(sw_vote), .sw_nonlatch(sw_nonlatch),
        .sw_slave(sw_slave), .test_pin(test_pin), .creset_pin(creset_pin),
        .bus_cnt_in(bus_cnt_in), .bus_strb_in(bus_strb_in), .bus_cnt_out(bus_cnt_out),
        .fire_a_o(fire_a_o), .fire_b_o(fire_b_o), .led_fire_a(led_fire_a),
        .led_fire_b(led_fire_b), .led_zone(led_zone)
    );

    fzv_field i_fzv_field (
        .sys_clk(sys_clk), .go(go), .zmask(zmask), .npulse(npulse), .up_go(up_go),
        .up_cnt(up_cnt), .det_pulse(det_pulse), .busy(fbusy), .bus_cnt_in(bus_cnt_in),
        .bus_strb_in(bus_strb_in)
    );

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic boot(input logic [3:0] g, input logic [3:0] v, input logic nl,
                        input logic sl, input logic tm);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        sw_gates <= g;
        sw_vote <= v;
        sw_nonlatch <= nl;
        sw_slave <= sl;
        test_pin <= tm;
        cyc(10);
        rst_n <= 1'b1;
        cyc(8);
    endtask

    // One gate interval: a burst of n pulses on the masked zones, then the gate tick.
    task automatic gate(input logic [7:0] m, input logic [3:0] n);
        zmask <= m;
        npulse <= n;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        cyc(2);
        repeat (200) if (fbusy) @(posedge sys_clk);
        cyc(8);
        gate_tick <= 1'b1;
        @(posedge sys_clk);
        gate_tick <= 1'b0;
        cyc(6);
    endtask

    task automatic fire(input logic [7:0] m);
        gate(m, 4'h2);
        gate(m, 4'h2);
    endtask

    task automatic send_up(input logic [6:0] w);
        up_cnt <= w;
        up_go <= 1'b1;
        @(posedge sys_clk);
        up_go <= 1'b0;
        cyc(24);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_gates();
        boot(4'h1, 4'h1, 1'b0, 1'b0, 1'b0);
        sw_gates <= 4'hF;
        gate(8'h01, 4'h2);
        chk("zone after one gate", 8'h00, led_zone);
        gate(8'h01, 4'h2);
        chk("zone after two gates", 8'h01, led_zone);
        boot(4'h3, 4'h1, 1'b0, 1'b0, 1'b0);
        gate(8'h01, 4'h2);
        gate(8'h01, 4'h2);
        gate(8'h01, 4'h1);
        chk("zone short gate", 8'h00, led_zone);
        gate(8'h01, 4'h2);
        gate(8'h01, 4'h2);
        chk("zone run restarted", 8'h00, led_zone);
        gate(8'h01, 4'h2);
        chk("zone after three gates", 8'h01, led_zone);
    endtask

    task automatic t_sep();
        boot(4'h1, 4'b1011, 1'b0, 1'b0, 1'b0);
        fire(8'h10);
        chk("sep b one of four", 8'h01, {7'h00, fire_b_o});
        chk("sep a untouched", 8'h00, {7'h00, fire_a_o});
        fire(8'h01);
        chk("sep a one zone", 8'h00, {7'h00, fire_a_o});
        gate(8'h00, 4'h0);
        fire(8'h02);
        chk("sep a cumulative", 8'h01, {7'h00, fire_a_o});
        chk("sep led a cumulative", 8'h01, {7'h00, led_fire_a});
        gate(8'h00, 4'h0);
        chk("latched a held", 8'h01, {7'h00, fire_a_o});
        creset_pin <= 1'b1;
        cyc(6);
        creset_pin <= 1'b0;
        cyc(8);
        chk("a after creset", 8'h00, {7'h00, fire_a_o});
        chk("zones after creset", 8'h00, led_zone);
    endtask

    task automatic t_nonlatch();
        boot(4'h1, 4'b0101, 1'b1, 1'b0, 1'b0);
        fire(8'h30);
        chk("b two live zones", 8'h01, {7'h00, fire_b_o});
        gate(8'h10, 4'h2);
        chk("b one live zone", 8'h00, {7'h00, fire_b_o});
        chk("led b one live zone", 8'h00, {7'h00, led_fire_b});
    endtask

    task automatic t_test();
        boot(4'h1, 4'b0000, 1'b1, 1'b0, 1'b1);
        strobes = 0;
        fire(8'h01);
        chk("test led b", 8'h01, {7'h00, led_fire_b});
        chk("test out b", 8'h00, {7'h00, fire_b_o});
        gate(8'h00, 4'h0);
        chk("test led b latched", 8'h01, {7'h00, led_fire_b});
        chk("test bus word", 8'h00, {1'b0, bus_cnt_out});
        chk("test strobe count", 8'h00, 8'(strobes));
    endtask

    task automatic t_common();
        boot(4'h1, 4'b0110, 1'b0, 1'b1, 1'b0);
        strobes = 0;
        send_up(7'h02);
        chk("common below threshold", 8'h00, {7'h00, fire_b_o});
        fire(8'h01);
        chk("slave bus word", 8'h03, {1'b0, bus_cnt_out});
        chk("last slave b", 8'h01, {7'h00, fire_b_o});
        chk("strobe count", 8'h02, 8'(strobes));
        boot(4'h1, 4'b0010, 1'b0, 1'b0, 1'b0);
        send_up(7'h05);
        chk("master ignores bus", 8'h00, {1'b0, bus_cnt_out});
        chk("master b idle", 8'h00, {7'h00, fire_b_o});
        fire(8'h01);
        chk("master local word", 8'h01, {1'b0, bus_cnt_out});
        chk("master b one zone", 8'h01, {7'h00, fire_b_o});
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        t_gates();
        t_sep();
        t_nonlatch();
        t_test();
        t_common();
        conclude();
    end

    initial begin
        cyc(30000);
        err_total++;
        conclude();
    end
endmodule
